// ---- design/cbcu_pkg.sv ----
package cbcu_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PC = 8'h14;
  localparam logic [7:0] OFF_VECT = 8'h18;

  // Fixed addresses and values after reset.
  localparam logic [15:0] NMI_ADDR = 16'h0066;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [1:0] RESET_MODE = 2'h0;
  localparam logic [3:0] SYNC_IDLE = 4'hF;

  // Two idle states after reset release, counted 0 to START_LAST.
  localparam logic [1:0] START_LAST = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_T1 = 3'h2,
    ST_T2 = 3'h3,
    ST_TW = 3'h4,
    ST_T3 = 3'h5,
    ST_T4 = 3'h6,
    ST_HOLD = 3'h7
  } cbcu_state_e;

  typedef enum logic [2:0] {
    KD_FETCH = 3'h0,
    KD_MRD = 3'h1,
    KD_MWR = 3'h2,
    KD_IORD = 3'h3,
    KD_IOWR = 3'h4,
    KD_HALT = 3'h5,
    KD_INTA = 3'h6,
    KD_NMIA = 3'h7
  } cbcu_kind_e;

  typedef struct packed {
    logic [7:0] data;
    logic waitN;
    logic busHoldRequestN;
    logic nonmaskableIrqN;
    logic maskableIrqLineN;
  } cbcu_pin_in_s;

  typedef struct packed {
    logic [15:0] addr;
    logic addrOeN;
    logic [7:0] data;
    logic dataOeN;
    logic memoryRequestN;
    logic ioRequestN;
    logic readStrobeN;
    logic storeStrobeN;
    logic ctlOeN;
    logic firstCycleMarkerN;
    logic refreshStrobeN;
    logic haltN;
    logic busGrantOutN;
  } cbcu_pin_out_s;

  typedef struct packed {
    cbcu_state_e st;
    cbcu_kind_e kind;
    logic [1:0] cnt;
    logic autoW;
    logic last;
    logic evalP;
    logic halted;
    logic irqEnableFlop;
    logic [1:0] mode;
    logic nmiP;
    logic nmiPrev;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [15:0] pc;
    logic [15:0] addrReg;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] iReg;
    logic [6:0] rReg;
    logic [7:0] vec;
    logic cmdP;
    cbcu_kind_e cmdKind;
    logic cmdLast;
    logic [15:0] addrOut;
    logic [7:0] dataOut;
    logic [31:0] prdata;
    logic pslverr;
  } cbcu_state_s;

endpackage

// ---- design/cbcu_bus_control.sv ----
`timescale 1ns/1ps

// Notes on behaviour
// - Bus grant goes low only while address, data and strobes float.
// - Bus hold request is honoured at the end of every machine cycle.
// - During a granted hold, buses and memory/io strobes stay floating.
// - One eight bit three-state data bus carries all memory and io data.
// - Halt holds halt low, repeats refresh no-op cycles until an interrupt.
// - Maskable request is taken at instruction end only with enable flop set.
// - I/O request is active while the low address half holds the port.
// - Interrupt acknowledge shows io request with first cycle marker.
// - Fetch shows marker with memory request; memory request marks valid address.
// - Non-maskable falling edge is taken at instruction end, jumps to 0066H.
// - Reset clears enable flop, program counter, vector and refresh registers.
// - While reset is active buses float and controls are inactive.
// - Two idle states follow reset release; first fetch is from 0000H.
// - Refresh strobe with memory request marks a seven bit refresh address.
// - Wait states repeat for as long as the wait input is active.
// - Memory write: request on stable address, store strobe on stable data.
// - Every io cycle gets one automatic wait state besides external ones.
// - Non-maskable acknowledge reads like memory, drops data, restarts.
// - Both interrupt inputs are sampled together; non-maskable wins.
// - A stopped clock freezes all registers; outputs still follow reset and the APB select and enable.
// - Interrupt inputs are sampled at the last clock state of an instruction.
module cbcu_bus_control (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input cbcu_pkg::cbcu_pin_in_s pinsIn,
  output cbcu_pkg::cbcu_pin_out_s pinsOut
);

  cbcu_pkg::cbcu_state_s r;
  cbcu_pkg::cbcu_state_s next_r;

  logic waitOn;
  logic holdOn;
  logic intOn;
  logic nmiEdge;
  logic nmiTake;
  logic nmiPend;
  logic busy;
  logic go;
  cbcu_pkg::cbcu_kind_e goKind;
  logic [15:0] goAddr;
  logic goLast;
  logic inT;
  logic midT3;
  logic fetchLike;
  logic memCyc;
  logic ioCyc;
  logic wrCyc;
  logic refr;
  logic run;
  logic setup;
  logic access;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins and decoded cycle attributes.

  assign waitOn = ~r.s2[3];
  assign holdOn = ~r.s2[2];
  assign intOn = ~r.s2[0];
  assign nmiEdge = r.nmiPrev & ~r.s2[1];
  // An edge seen this cycle counts at once, so it meets the maskable level.
  assign nmiPend = r.nmiP | nmiEdge;
  assign busy = r.cmdP | r.halted | (r.st != cbcu_pkg::ST_IDLE);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign run = ~reset;
  assign inT = (r.st == cbcu_pkg::ST_T1) | (r.st == cbcu_pkg::ST_T2) |
               (r.st == cbcu_pkg::ST_TW) | (r.st == cbcu_pkg::ST_T3) |
               (r.st == cbcu_pkg::ST_T4);
  assign midT3 = (r.st == cbcu_pkg::ST_T2) | (r.st == cbcu_pkg::ST_TW) |
                 (r.st == cbcu_pkg::ST_T3);
  assign fetchLike = (r.kind == cbcu_pkg::KD_FETCH) |
                     (r.kind == cbcu_pkg::KD_NMIA);
  assign memCyc = fetchLike | (r.kind == cbcu_pkg::KD_MRD) |
                  (r.kind == cbcu_pkg::KD_MWR);
  assign ioCyc = (r.kind == cbcu_pkg::KD_IORD) |
                 (r.kind == cbcu_pkg::KD_IOWR);
  assign wrCyc = (r.kind == cbcu_pkg::KD_MWR) |
                 (r.kind == cbcu_pkg::KD_IOWR);
  assign refr = fetchLike &
                ((r.st == cbcu_pkg::ST_T3) | (r.st == cbcu_pkg::ST_T4));

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_r = r;
    nmiTake = 1'b0;
    go = 1'b0;
    goKind = cbcu_pkg::KD_FETCH;
    goAddr = r.pc;
    goLast = 1'b1;
    next_r.s1 = {pinsIn.waitN, pinsIn.busHoldRequestN,
                 pinsIn.nonmaskableIrqN, pinsIn.maskableIrqLineN};
    next_r.s2 = r.s1;
    next_r.nmiPrev = r.s2[1];

    // APB read data and error are formed in the setup phase.
    if (setup) begin
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0000_0000;
      case (paddr)
        cbcu_pkg::OFF_CMD: begin
          next_r.prdata[3:0] = {r.cmdLast, r.cmdKind};
          next_r.pslverr = pwrite & busy;
        end
        cbcu_pkg::OFF_ADDR: next_r.prdata[15:0] = r.addrReg;
        cbcu_pkg::OFF_WDATA: next_r.prdata[7:0] = r.wdata;
        cbcu_pkg::OFF_CTRL: next_r.prdata[2:0] = {r.mode, r.irqEnableFlop};
        cbcu_pkg::OFF_STATUS: begin
          next_r.prdata[15:8] = r.rdata;
          next_r.prdata[4:0] = {r.st == cbcu_pkg::ST_START, r.nmiP,
                                r.st == cbcu_pkg::ST_HOLD, r.halted, busy};
        end
        cbcu_pkg::OFF_PC: next_r.prdata[15:0] = r.pc;
        cbcu_pkg::OFF_VECT: next_r.prdata[23:0] = {r.vec, 1'b0, r.rReg,
                                                    r.iReg};
        default: next_r.pslverr = 1'b1;
      endcase
    end

    // Writes take effect in the access phase unless refused in setup.
    if (access & pwrite & ~r.pslverr) begin
      case (paddr)
        cbcu_pkg::OFF_CMD: begin
          next_r.cmdP = 1'b1;
          next_r.cmdKind = cbcu_pkg::cbcu_kind_e'(pwdata[2:0]);
          next_r.cmdLast = pwdata[3];
        end
        cbcu_pkg::OFF_ADDR: next_r.addrReg = pwdata[15:0];
        cbcu_pkg::OFF_WDATA: next_r.wdata = pwdata[7:0];
        cbcu_pkg::OFF_CTRL: begin
          next_r.irqEnableFlop = pwdata[0];
          next_r.mode = pwdata[2:1];
        end
        cbcu_pkg::OFF_PC: next_r.pc = pwdata[15:0];
        cbcu_pkg::OFF_VECT: next_r.iReg = pwdata[7:0];
        default: ;
      endcase
    end

    unique case (r.st)
      cbcu_pkg::ST_START: begin
        if (r.cnt == cbcu_pkg::START_LAST) begin
          next_r.st = cbcu_pkg::ST_IDLE;
        end else begin
          next_r.cnt = r.cnt + 2'h1;
        end
      end
      cbcu_pkg::ST_IDLE: begin
        // Requests are weighed in fixed priority at the boundary.
        if (holdOn) begin
          next_r.st = cbcu_pkg::ST_HOLD;
        end else if (r.evalP & nmiPend) begin
          nmiTake = 1'b1;
          go = 1'b1;
          goKind = cbcu_pkg::KD_NMIA;
          next_r.irqEnableFlop = 1'b0;
          next_r.halted = 1'b0;
          next_r.evalP = 1'b0;
        end else if (r.evalP & intOn & r.irqEnableFlop) begin
          go = 1'b1;
          goKind = cbcu_pkg::KD_INTA;
          next_r.irqEnableFlop = 1'b0;
          next_r.halted = 1'b0;
          next_r.evalP = 1'b0;
        end else if (r.halted) begin
          go = 1'b1;
          next_r.evalP = 1'b0;
        end else if (r.cmdP) begin
          next_r.cmdP = 1'b0;
          next_r.evalP = 1'b0;
          if (r.cmdKind == cbcu_pkg::KD_HALT) begin
            next_r.halted = 1'b1;
            next_r.evalP = 1'b1;
          end else begin
            go = 1'b1;
            goKind = r.cmdKind;
            goLast = r.cmdLast;
            if (r.cmdKind == cbcu_pkg::KD_FETCH) begin
              next_r.pc = r.pc + 16'h0001;
            end else begin
              goAddr = r.addrReg;
            end
          end
        end else begin
          next_r.evalP = 1'b0;
        end
      end
      cbcu_pkg::ST_T1: next_r.st = cbcu_pkg::ST_T2;
      cbcu_pkg::ST_T2, cbcu_pkg::ST_TW: begin
        if ((r.st == cbcu_pkg::ST_T2) & r.autoW) begin
          next_r.st = cbcu_pkg::ST_TW;
          next_r.autoW = 1'b0;
        end else if (waitOn) begin
          next_r.st = cbcu_pkg::ST_TW;
        end else begin
          next_r.st = cbcu_pkg::ST_T3;
          if (fetchLike) begin
            next_r.addrOut = {r.iReg, 1'b0, r.rReg};
          end
          if ((r.kind == cbcu_pkg::KD_FETCH) | (r.kind == cbcu_pkg::KD_MRD) |
              (r.kind == cbcu_pkg::KD_IORD)) begin
            next_r.rdata = pinsIn.data;
          end
          if (r.kind == cbcu_pkg::KD_INTA) begin
            next_r.vec = pinsIn.data;
          end
        end
      end
      cbcu_pkg::ST_T3, cbcu_pkg::ST_T4: begin
        if ((r.st == cbcu_pkg::ST_T3) & fetchLike) begin
          next_r.st = cbcu_pkg::ST_T4;
        end else begin
          // End of machine cycle: hold request is checked here.
          next_r.st = holdOn ? cbcu_pkg::ST_HOLD : cbcu_pkg::ST_IDLE;
          next_r.evalP = r.last;
          if (fetchLike) begin
            next_r.rReg = r.rReg + 7'h01;
          end
          if (r.kind == cbcu_pkg::KD_NMIA) begin
            next_r.pc = cbcu_pkg::NMI_ADDR;
          end
        end
      end
      cbcu_pkg::ST_HOLD: begin
        if (~holdOn) begin
          next_r.st = cbcu_pkg::ST_IDLE;
        end
      end
    endcase

    if (go) begin
      next_r.st = cbcu_pkg::ST_T1;
      next_r.kind = goKind;
      next_r.last = goLast;
      next_r.addrOut = goAddr;
      next_r.dataOut = r.wdata;
      next_r.autoW = (goKind == cbcu_pkg::KD_IORD) |
                     (goKind == cbcu_pkg::KD_IOWR) |
                     (goKind == cbcu_pkg::KD_INTA);
    end

    // A take consumes one request; a fresh edge on top of an older one
    // in the take cycle stays pending; edges before a take merge into one.
    next_r.nmiP = nmiTake ? (r.nmiP & nmiEdge) : nmiPend;
  end

  // A stopped clock leaves every flop as is; outputs still follow reset, and pready and pslverr follow psel and penable.
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
      r.st <= cbcu_pkg::ST_START;
      r.kind <= cbcu_pkg::KD_FETCH;
      r.cmdKind <= cbcu_pkg::KD_FETCH;
      r.pc <= cbcu_pkg::RESET_PC;
      r.mode <= cbcu_pkg::RESET_MODE;
      r.s1 <= cbcu_pkg::SYNC_IDLE;
      r.s2 <= cbcu_pkg::SYNC_IDLE;
      r.nmiPrev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and bus outputs.

  assign prdata = r.prdata;
  assign pready = access;
  assign pslverr = access & r.pslverr;

  always_comb begin
    pinsOut.addr = r.addrOut;
    pinsOut.data = r.dataOut;
    pinsOut.addrOeN = ~(run & inT);
    pinsOut.dataOeN = ~(run & inT & wrCyc);
    pinsOut.ctlOeN = run & (r.st == cbcu_pkg::ST_HOLD);
    pinsOut.memoryRequestN = ~(run & inT & memCyc);
    pinsOut.ioRequestN = ~(run & midT3 &
                           (ioCyc | (r.kind == cbcu_pkg::KD_INTA)));
    pinsOut.readStrobeN = ~(run & ~refr & ~wrCyc &
                            (r.kind != cbcu_pkg::KD_INTA) &
                            (memCyc ? inT : midT3));
    pinsOut.storeStrobeN = ~(run & wrCyc & midT3);
    pinsOut.firstCycleMarkerN = ~(run &
      ((fetchLike & inT & ~refr) |
       ((r.kind == cbcu_pkg::KD_INTA) & inT)));
    pinsOut.refreshStrobeN = ~(run & refr);
    pinsOut.haltN = ~(run & r.halted);
    pinsOut.busGrantOutN = ~(run & (r.st == cbcu_pkg::ST_HOLD));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  chk_grant_float: assert property (
    !pinsOut.busGrantOutN |-> pinsOut.addrOeN && pinsOut.dataOeN &&
      pinsOut.ctlOeN)
    else $error("bus grant low while bus is driven");

  chk_hold_entry: assert property (
    (((r.st == cbcu_pkg::ST_T3) && !fetchLike) ||
      (r.st == cbcu_pkg::ST_T4)) && holdOn
      |=> (r.st == cbcu_pkg::ST_HOLD) && !pinsOut.busGrantOutN)
    else $error("hold request not honoured at cycle end");

  chk_hold_float: assert property (
    (r.st == cbcu_pkg::ST_HOLD) && holdOn |=>
      (r.st == cbcu_pkg::ST_HOLD) && pinsOut.ctlOeN)
    else $error("hold released while still requested");

  chk_halt_refresh: assert property (
    r.halted && (r.st == cbcu_pkg::ST_T4) |->
      !pinsOut.refreshStrobeN && !pinsOut.memoryRequestN && !pinsOut.haltN)
    else $error("halted no-op cycle without refresh");

  chk_int_masked: assert property (
    (r.st == cbcu_pkg::ST_IDLE) && !holdOn && r.evalP && !r.nmiP &&
      !r.irqEnableFlop |=> r.kind != cbcu_pkg::KD_INTA ||
      r.st != cbcu_pkg::ST_T1)
    else $error("masked interrupt acknowledged");

  chk_io_addr: assert property (
    !pinsOut.ioRequestN |-> !pinsOut.addrOeN)
    else $error("io request without a driven address");

  chk_ack_kind: assert property (
    !pinsOut.ioRequestN && !pinsOut.firstCycleMarkerN |->
      r.kind == cbcu_pkg::KD_INTA)
    else $error("marker with io request outside acknowledge");

  chk_nmi_vector: assert property (
    (r.st == cbcu_pkg::ST_T4) && (r.kind == cbcu_pkg::KD_NMIA) |=>
      r.pc == cbcu_pkg::NMI_ADDR)
    else $error("non-maskable restart address wrong");

  chk_start_two: assert property (
    (r.st == cbcu_pkg::ST_START) && (r.cnt == 2'h0) |=>
      (r.st == cbcu_pkg::ST_START) ##1 (r.st == cbcu_pkg::ST_IDLE))
    else $error("start-up idle states not two");

  chk_wait_stay: assert property (
    (r.st == cbcu_pkg::ST_TW) && waitOn |=> r.st == cbcu_pkg::ST_TW)
    else $error("wait state left while wait active");

  chk_io_autowait: assert property (
    (r.st == cbcu_pkg::ST_T1) && ioCyc |=> ##1 r.st == cbcu_pkg::ST_TW)
    else $error("io cycle without automatic wait");

  chk_nmi_wins: assert property (
    (r.st == cbcu_pkg::ST_IDLE) && !holdOn && r.evalP && nmiPend && intOn
      |=> (r.st == cbcu_pkg::ST_T1) && (r.kind == cbcu_pkg::KD_NMIA))
    else $error("maskable request beat non-maskable");

endmodule

// ---- tb/cbcu_mem_model.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module cbcu_mem_model (
  input wire logic clock,
  input cbcu_pkg::cbcu_pin_out_s pinsOut,
  input wire logic [7:0] vector,
  input wire logic waitHold,
  output logic waitN,
  output logic [7:0] busOut,
  output logic [7:0] ioData
);
  logic [7:0] mem [256];
  logic [7:0] lastOut;
  logic [7:0] value;
  logic ctl, readMem, readIo, intAck, driving;

  assign ctl = !pinsOut.ctlOeN;
  assign intAck = !pinsOut.ioRequestN && !pinsOut.firstCycleMarkerN;
  assign readMem = ctl && !pinsOut.memoryRequestN && !pinsOut.readStrobeN;
  assign readIo = ctl && !pinsOut.ioRequestN && !pinsOut.readStrobeN;
  assign driving = readMem || readIo || intAck;
  assign value = intAck ? vector : (readIo ? ioData : mem[pinsOut.addr[7:0]]);
  // A released bus shows the inverse of the last byte, never a held value.
  assign busOut = driving ? value : ~lastOut;
  assign waitN = !waitHold;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    ioData = 8'h00;
    lastOut = 8'h00;
  end

  always @(posedge clock) begin
    if (driving) begin
      lastOut <= value;
    end
    if (ctl && !pinsOut.storeStrobeN && !pinsOut.memoryRequestN) begin
      mem[pinsOut.addr[7:0]] <= pinsOut.data;
    end
    if (ctl && !pinsOut.storeStrobeN && !pinsOut.ioRequestN) begin
      ioData <= pinsOut.data;
    end
  end
endmodule

// ---- tb/cbcu_bus_control_bench.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module cbcu_bus_control_bench;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, apbErr;
  logic [7:0] paddr, vector, busOut, ioData, refHi, portLo;
  logic [31:0] pwdata, prdata, r;
  logic waitHold, modelWaitN, holdN, nmiN, irqN, fetchSeen;
  logic [15:0] firstFetch;
  cbcu_pkg::cbcu_pin_in_s pinsIn;
  cbcu_pkg::cbcu_pin_out_s pinsOut;
  int bad_count, checks, cycles, refCycles, intaCycles, ioLow, memLow, n;

  assign pinsIn = {(pinsOut.dataOeN ? busOut : pinsOut.data), modelWaitN,
    holdN, nmiN, irqN};

  cbcu_bus_control dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinsIn(pinsIn),
    .pinsOut(pinsOut));

  cbcu_mem_model model (.clock(clock), .pinsOut(pinsOut), .vector(vector),
    .waitHold(waitHold), .waitN(modelWaitN), .busOut(busOut),
    .ioData(ioData));

  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    apbErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Polls one status bit until it reads the wanted level.
  task poll(input int b, input logic val);
    int k;
    k = 0;
    do begin
      rd(cbcu_pkg::OFF_STATUS);
      k++;
    end while (r[b] !== val && k < 60);
    check("status bit", 32'(r[b]), 32'(val));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (!reset && !pinsOut.ctlOeN) begin
      if (!pinsOut.memoryRequestN && !pinsOut.firstCycleMarkerN &&
          !fetchSeen) begin
        fetchSeen = 1'b1;
        firstFetch = pinsOut.addr;
      end
      if (!pinsOut.memoryRequestN && !pinsOut.refreshStrobeN) begin
        refCycles++;
        refHi = pinsOut.addr[15:8];
      end
      if (!pinsOut.ioRequestN && !pinsOut.firstCycleMarkerN) intaCycles++;
      if (!pinsOut.ioRequestN && pinsOut.firstCycleMarkerN) begin
        ioLow++;
        portLo = pinsOut.addr[7:0];
      end
      if (!pinsOut.memoryRequestN) memLow++;
    end
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    {reset, holdN, nmiN, irqN} = 4'hF;
    {psel, penable, pwrite, waitHold, fetchSeen} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    vector = 8'h3C;
    {bad_count, checks, cycles, refCycles, intaCycles, ioLow, memLow} = '0;
    repeat (10) @(posedge clock);
    check("reset pins", {24'h0, pinsOut.addrOeN, pinsOut.dataOeN,
      pinsOut.memoryRequestN, pinsOut.ioRequestN, pinsOut.readStrobeN,
      pinsOut.storeStrobeN, pinsOut.haltN, pinsOut.busGrantOutN},
      32'hFF);
    reset <= 1'b0;
    rd(cbcu_pkg::OFF_PC);
    check("pc", r, 32'h0);
    rd(cbcu_pkg::OFF_CTRL);
    check("ctrl", r, 32'h0);
    rd(cbcu_pkg::OFF_VECT);
    check("vect", r & 32'h7FFF, 32'h0);
    rd(8'h1C);
    check("unmapped", {apbErr, r[30:0]}, 32'h80000000);
    wr(cbcu_pkg::OFF_VECT, 32'h12);
    wr(cbcu_pkg::OFF_CMD, 32'h8);
    poll(0, 1'b0);
    check("first fetch", {16'h0, firstFetch}, 32'h0);
    rd(cbcu_pkg::OFF_STATUS);
    check("fetch data", {24'h0, r[15:8]}, 32'h5A);
    check("refresh row", {24'h0, refHi}, 32'h12);
    rd(cbcu_pkg::OFF_PC);
    check("pc step", r, 32'h1);
    wr(cbcu_pkg::OFF_ADDR, 32'h42);
    wr(cbcu_pkg::OFF_WDATA, 32'hA5);
    wr(cbcu_pkg::OFF_CMD, 32'hA);
    poll(0, 1'b0);
    check("mem write", {24'h0, model.mem[8'h42]}, 32'hA5);
    memLow = 0;
    wr(cbcu_pkg::OFF_CMD, 32'h9);
    poll(0, 1'b0);
    check("mem read len", 32'(memLow), 32'h3);
    rd(cbcu_pkg::OFF_STATUS);
    check("mem read", {24'h0, r[15:8]}, 32'hA5);
    wr(cbcu_pkg::OFF_ADDR, 32'h3377);
    wr(cbcu_pkg::OFF_WDATA, 32'h6B);
    ioLow = 0;
    wr(cbcu_pkg::OFF_CMD, 32'hC);
    poll(0, 1'b0);
    check("io len", 32'(ioLow), 32'h3);
    check("port", {24'h0, portLo}, 32'h77);
    check("io write", {24'h0, ioData}, 32'h6B);
    wr(cbcu_pkg::OFF_CMD, 32'hB);
    poll(0, 1'b0);
    rd(cbcu_pkg::OFF_STATUS);
    check("io read", {24'h0, r[15:8]}, 32'h6B);
    waitHold <= 1'b1;
    wr(cbcu_pkg::OFF_CMD, 32'h9);
    repeat (20) @(posedge clock);
    check("wait stall", 32'(pinsOut.memoryRequestN), 32'h0);
    wr(cbcu_pkg::OFF_CMD, 32'h8);
    check("busy refuse", 32'(apbErr), 32'h1);
    holdN <= 1'b0;
    repeat (5) @(posedge clock);
    check("hold mid cycle", 32'(pinsOut.busGrantOutN), 32'h1);
    waitHold <= 1'b0;
    repeat (10) @(posedge clock);
    check("hold at end", 32'(pinsOut.busGrantOutN), 32'h0);
    check("hold float", 32'(pinsOut.ctlOeN), 32'h1);
    holdN <= 1'b1;
    poll(0, 1'b0);
    wr(cbcu_pkg::OFF_CMD, 32'hD);
    repeat (5) @(posedge clock);
    n = refCycles;
    irqN <= 1'b0;
    repeat (30) @(posedge clock);
    check("halt", 32'(pinsOut.haltN), 32'h0);
    check("halt refresh", 32'(refCycles > n), 32'h1);
    wr(cbcu_pkg::OFF_CTRL, 32'h1);
    poll(1, 1'b0);
    poll(0, 1'b0);
    irqN <= 1'b1;
    rd(cbcu_pkg::OFF_VECT);
    check("int vector", {24'h0, r[23:16]}, 32'h3C);
    check("halt exit", 32'(pinsOut.haltN), 32'h1);
    wr(cbcu_pkg::OFF_CTRL, 32'h1);
    wr(cbcu_pkg::OFF_CMD, 32'hD);
    repeat (5) @(posedge clock);
    n = intaCycles;
    irqN <= 1'b0;
    nmiN <= 1'b0;
    poll(1, 1'b0);
    poll(0, 1'b0);
    nmiN <= 1'b1;
    rd(cbcu_pkg::OFF_PC);
    check("nmi pc", r, 32'(cbcu_pkg::NMI_ADDR));
    check("nmi wins", 32'(intaCycles - n), 32'h0);
    rd(cbcu_pkg::OFF_CTRL);
    check("flop off", 32'(r[0]), 32'h0);
    irqN <= 1'b1;
    holdN <= 1'b0;
    n = 0;
    while (pinsOut.busGrantOutN !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    check("grant", 32'(pinsOut.busGrantOutN), 32'h0);
    check("float", {29'h0, pinsOut.ctlOeN, pinsOut.addrOeN,
      pinsOut.dataOeN}, 32'h7);
    holdN <= 1'b1;
    repeat (10) @(posedge clock);
    check("grant off", 32'(pinsOut.busGrantOutN), 32'h1);
    wr(cbcu_pkg::OFF_CTRL, 32'h5);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(cbcu_pkg::OFF_PC);
    check("pc again", r, 32'h0);
    rd(cbcu_pkg::OFF_CTRL);
    check("ctrl again", r, 32'h0);
    rd(cbcu_pkg::OFF_VECT);
    check("vect again", r & 32'h7FFF, 32'h0);
    give_verdict();
  end
endmodule
